// >>> hdl/nvs_timing_regs.vh
// timing constants for the store/recall sequencer
`ifndef NVS_TIMING_REGS_VH
`define NVS_TIMING_REGS_VH
`define NVS_CLK_MHZ 250
`define NVS_T_RECALL_PU_MS 20
`define NVS_T_STORE_MS 8
`define NVS_T_DELAY_NS 25
`define NVS_T_WAKE_MS 20
`define NVS_T_SLEEP_MS 8
`define NVS_T_STANDBY_US 100
`define NVS_T_SOFTSEQ_US 500
`define NVS_T_RECALL_US 600
`define NVS_CNT_W 23
// the same times as cycle counts at 250 MHz, sized to the counters
`define NVS_RECALL_PU_CYC 23'h4c4b40
`define NVS_STORE_CYC 23'h1e8480
`define NVS_WAKE_CYC 23'h4c4b40
`define NVS_SLEEP_CYC 23'h1e8480
`define NVS_STANDBY_CYC 23'h61a8
`define NVS_SOFTSEQ_CYC 23'h1e848
`define NVS_RECALL_CYC 23'h249f0
`define NVS_DELAY_CYC 23'h6
`define NVS_SB_LAT 23'h4
`endif

// >>> hdl/nvs_sequencer.v
// store/recall, sleep and standby timing sequencer of a serial nvsram
// Operation
// R1: power-up restore completes within 20 ms after supply crosses trip level
// R2: power-fail save skipped when no sram write since last save or restore
// R3: sram access stays enabled 25 ns after a save or restore begins; on a power-fail save the code closes it at once
// R4: reads and writes ignored during save, restore, or low supply
// R5: wake-up from sleep completes within 20 ms
// R6: sleep entered within 8 ms of sleep command
// R7: standby entered within 100 us of chip select going high; the code enters it only from idle, so it waits for a running operation
// R8: special-function command acted upon within 500 us
// R9: serial i/o blocked during command save or restore; host waits
// R10: save within 8 ms, command restore within 600 us, busy reported
// R11: host polls busy or waits maximum time before next command
`timescale 1ns/1ps
`include "nvs_timing_regs.vh"
module nvs_sequencer #(
  // defaults are the worst-case times counted at 250 MHz
  parameter [22:0] RECALL_PU_CYC = `NVS_RECALL_PU_CYC,
  parameter [22:0] STORE_CYC = `NVS_STORE_CYC,
  parameter [22:0] WAKE_CYC = `NVS_WAKE_CYC,
  parameter [22:0] SLEEP_CYC = `NVS_SLEEP_CYC,
  parameter [22:0] STANDBY_CYC = `NVS_STANDBY_CYC,
  parameter [22:0] SOFTSEQ_CYC = `NVS_SOFTSEQ_CYC,
  parameter [22:0] RECALL_CYC = `NVS_RECALL_CYC
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // supply monitor and pins (asynchronous)
  input wire vcc_ok,
  input wire cs_b,
  // command decoder pulses (sys_clk domain)
  input wire cmd_store,
  input wire cmd_recall,
  input wire cmd_save_en,
  input wire cmd_save_dis,
  input wire cmd_sleep,
  input wire cmd_wake,
  input wire sram_write,
  // status and controls
  output reg sram_access_en_r,
  output reg io_blocked_r,
  output reg busy_r,
  output reg sleep_r,
  output reg standby_r,
  output reg nv_store_go_r,
  output reg nv_recall_go_r,
  output reg power_fail_save_en_r
);

  // delay count rounded down: longest time allowed
  localparam [22:0] DELAY_CYC = `NVS_DELAY_CYC;
  // reload trimmed by the sync and output register latency
  localparam [22:0] SB_RELOAD = STANDBY_CYC - `NVS_SB_LAT;

  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_RECALL = 3'h1;
  localparam [2:0] ST_IDLE = 3'h2;
  localparam [2:0] ST_PEND = 3'h3;
  localparam [2:0] ST_STORE = 3'h4;
  localparam [2:0] ST_SWREC = 3'h5;
  localparam [2:0] ST_SLEEP = 3'h6;
  localparam [2:0] ST_WAKE = 3'h7;

  localparam [1:0] OP_STORE = 2'h0;
  localparam [1:0] OP_RECALL = 2'h1;
  localparam [1:0] OP_CFG = 2'h2;
  localparam [1:0] OP_SLEEP = 2'h3;

  reg vcc_m_r, vcc_s_r, cs_m_r, cs_s_r;
  reg [2:0] st_r, st_nxt;
  reg [22:0] cnt_r, cnt_nxt;
  reg [22:0] gate_r, gate_nxt;
  reg [22:0] sb_cnt_r;
  reg [1:0] op_r, op_nxt;
  reg dirty_r, dirty_nxt;
  reg cfg_nxt;

  function [22:0] dec_sat;
    input [22:0] v;
    begin
      dec_sat = (v == 23'h0) ? 23'h0 : v - 23'h1;
    end
  endfunction

  // cs_b resets to its idle level so no false release follows reset
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vcc_m_r <= 1'b0;
      vcc_s_r <= 1'b0;
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
    end else begin
      vcc_m_r <= vcc_ok;
      vcc_s_r <= vcc_m_r;
      cs_m_r <= cs_b;
      cs_s_r <= cs_m_r;
    end
  end

  // states in which the nv array or the wake-up logic is active
  wire nv_busy = (st_r == ST_RECALL) || (st_r == ST_STORE) || (st_r == ST_SWREC) ||
    (st_r == ST_WAKE) || (st_r == ST_OFF);

  always @* begin
    st_nxt = st_r;
    cnt_nxt = dec_sat(cnt_r);
    gate_nxt = dec_sat(gate_r);
    op_nxt = op_r;
    cfg_nxt = power_fail_save_en_r;
    // writes count only while the access window is open
    dirty_nxt = dirty_r | (sram_write & sram_access_en_r & ~nv_busy);
    case (st_r)
      ST_OFF: begin
        if (vcc_s_r) begin
          st_nxt = ST_RECALL;
          cnt_nxt = RECALL_PU_CYC; // [R1]
        end
      end
      ST_RECALL, ST_SWREC, ST_STORE, ST_WAKE: begin
        if (cnt_r == 23'h0) begin
          st_nxt = ST_IDLE;
          if (st_r != ST_WAKE) dirty_nxt = 1'b0; // [R2]
        end
      end
      ST_IDLE: begin
        if (cmd_store | cmd_recall | cmd_save_en | cmd_save_dis | cmd_sleep) begin
          st_nxt = ST_PEND;
          cnt_nxt = SOFTSEQ_CYC; // [R8]
          gate_nxt = DELAY_CYC; // [R3]
          op_nxt = cmd_store ? OP_STORE : cmd_recall ? OP_RECALL :
            cmd_sleep ? OP_SLEEP : OP_CFG;
          if (cmd_save_en) cfg_nxt = 1'b1;
          if (cmd_save_dis) cfg_nxt = 1'b0;
        end
      end
      ST_PEND: begin
        // grace count over: start the selected operation
        if (gate_r == 23'h0) begin
          case (op_r)
            OP_STORE: begin
              st_nxt = ST_STORE;
              cnt_nxt = STORE_CYC; // [R10]
            end
            OP_RECALL: begin
              st_nxt = ST_SWREC;
              cnt_nxt = RECALL_CYC; // [R10]
            end
            OP_SLEEP: begin
              st_nxt = ST_SLEEP;
              cnt_nxt = SLEEP_CYC; // [R6]
            end
            default: st_nxt = ST_IDLE;
          endcase
        end
      end
      ST_SLEEP: begin
        if (cmd_wake) begin
          st_nxt = ST_WAKE;
          cnt_nxt = WAKE_CYC; // [R5]
        end
      end
      default: st_nxt = ST_OFF;
    endcase
    // supply loss wins over any state; save only when data changed
    if (!vcc_s_r && st_r != ST_OFF) begin
      st_nxt = ST_OFF;
      if (dirty_r && power_fail_save_en_r) begin
        gate_nxt = DELAY_CYC; // [R3]
        cnt_nxt = STORE_CYC;
      end else begin
        gate_nxt = 23'h0; // [R2]
        cnt_nxt = 23'h0;
      end
      dirty_nxt = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_OFF;
      cnt_r <= 23'h0;
      gate_r <= 23'h0;
      op_r <= OP_STORE;
      dirty_r <= 1'b0;
      sb_cnt_r <= 23'h0;
      sram_access_en_r <= 1'b0;
      io_blocked_r <= 1'b1;
      busy_r <= 1'b1;
      sleep_r <= 1'b0;
      standby_r <= 1'b0;
      nv_store_go_r <= 1'b0;
      nv_recall_go_r <= 1'b0;
      power_fail_save_en_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      gate_r <= gate_nxt;
      op_r <= op_nxt;
      dirty_r <= dirty_nxt;
      power_fail_save_en_r <= cfg_nxt;
      // access window closes once the grace count runs out
      sram_access_en_r <= vcc_s_r && (st_nxt == ST_IDLE ||
        (st_nxt == ST_PEND && gate_nxt != 23'h0)); // [R3] [R4]
      io_blocked_r <= (st_nxt != ST_IDLE) && (st_nxt != ST_SLEEP); // [R9]
      // busy also covers the sleep entry count, where commands would be lost
      busy_r <= (st_nxt != ST_IDLE) &&
        !(st_nxt == ST_SLEEP && cnt_nxt == 23'h0); // [R10] [R6]
      sleep_r <= (st_nxt == ST_SLEEP) && (cnt_nxt == 23'h0); // [R6]
      nv_store_go_r <= (st_nxt == ST_STORE) ||
        (st_nxt == ST_OFF && cnt_nxt != 23'h0); // [R2]
      nv_recall_go_r <= (st_nxt == ST_RECALL) || (st_nxt == ST_SWREC);
      // standby count restarts whenever chip select is low
      if (!cs_s_r)
        sb_cnt_r <= SB_RELOAD; // [R7]
      else
        sb_cnt_r <= dec_sat(sb_cnt_r);
      standby_r <= cs_s_r && (sb_cnt_r == 23'h0) && (st_nxt == ST_IDLE); // [R7]
    end
  end

endmodule // nvs_sequencer

// >>> test/nvs_seq_asserts.sv
// port assertions for the store/recall sequencer
`timescale 1ns/1ps
module nvs_seq_asserts #(
  parameter int RECALL_PU_CYC = 40, STORE_CYC = 60, WAKE_CYC = 50, SLEEP_CYC = 30,
  parameter int RECALL_CYC = 45
) (
  input wire sys_clk, rst_b, vcc_ok, cmd_store, cmd_sleep,
  input wire sram_access_en_r, io_blocked_r, busy_r, sleep_r, standby_r,
  input wire nv_store_go_r, nv_recall_go_r
);
  localparam int S = STORE_CYC + 4, R = RECALL_PU_CYC + RECALL_CYC;
  localparam int W = WAKE_CYC + 12, L = SLEEP_CYC + 12;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // raw vcc_ok leads the synced copy, so low supply only masks
  wire idle = !busy_r && !sleep_r && vcc_ok;
  a_cmd_taken: assert property (cmd_store && idle |-> ##[1:2] busy_r)
    else $error("store not taken");
  a_write_grace: assert property ($rose(busy_r) && sram_access_en_r && vcc_ok |->
    sram_access_en_r [*5])
    else $error("access cut early");
  a_access_lock: assert property ((nv_store_go_r || nv_recall_go_r) && vcc_ok |->
    io_blocked_r && !sram_access_en_r)
    else $error("access during nv op");
  a_store_len: assert property ($rose(nv_store_go_r) && vcc_ok |-> ##[1:S] !nv_store_go_r)
    else $error("store too long");
  a_recall_len: assert property ($rose(nv_recall_go_r) |-> ##[1:R] !nv_recall_go_r)
    else $error("recall too long");
  a_sleep_entry: assert property (cmd_sleep && idle |-> ##[1:L] sleep_r)
    else $error("sleep late");
  a_wake_ready: assert property ($fell(sleep_r) |-> ##[0:W] !busy_r)
    else $error("wake late");
  a_standby_idle: assert property ($rose(standby_r) |-> !busy_r && !sleep_r)
    else $error("standby while busy");
  a_done_open: assert property ($fell(busy_r) && vcc_ok && !sleep_r |-> sram_access_en_r)
    else $error("access not back");
  c_store: cover property ($rose(nv_store_go_r));
  c_sleep: cover property ($rose(sleep_r));
  c_standby: cover property ($rose(standby_r));
endmodule // nvs_seq_asserts
bind nvs_sequencer nvs_seq_asserts #(.RECALL_PU_CYC(RECALL_PU_CYC), .STORE_CYC(STORE_CYC),
  .WAKE_CYC(WAKE_CYC), .SLEEP_CYC(SLEEP_CYC), .RECALL_CYC(RECALL_CYC)) nvs_seq_asserts_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .vcc_ok(vcc_ok), .cmd_store(cmd_store),
  .cmd_sleep(cmd_sleep), .sram_access_en_r(sram_access_en_r), .io_blocked_r(io_blocked_r),
  .busy_r(busy_r), .sleep_r(sleep_r), .standby_r(standby_r), .nv_store_go_r(nv_store_go_r),
  .nv_recall_go_r(nv_recall_go_r));

// >>> test/nvs_host_model.sv
// host model issuing one-cycle command pulses
`timescale 1ns/1ps
module nvs_host_model (
  input wire sys_clk,
  input wire busy_r,
  output reg [5:0] cmd,
  output reg cs_b
);
  initial begin
    cmd = 6'h00;
    cs_b = 1'b1;
  end
  // commands sent while busy are dropped silently, so hold off
  task issue(input int k);
    @(posedge sys_clk);
    #1;
    while (busy_r !== 1'b0) begin
      @(posedge sys_clk);
      #1;
    end
    cs_b = 1'b0;
    cmd[k] = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd = 6'h00;
    cs_b = 1'b1;
  endtask
endmodule // nvs_host_model

// >>> test/tb.sv
// self-checking bench for the store/recall sequencer
`timescale 1ns/1ps
module tb;
  reg sys_clk = 0;
  reg rst_b = 0;
  reg vcc_ok = 1;
  reg wr = 0;
  wire [5:0] cmd;
  wire cs_b, acc, iob, busy, slp, sb, sgo, rgo, pfs;
  int mismatches = 0;
  int compares = 0;
  int n;
  always #2 sys_clk = ~sys_clk;
  nvs_host_model nvs_host_model_inst (.sys_clk(sys_clk), .busy_r(busy), .cmd(cmd), .cs_b(cs_b));
  nvs_sequencer #(.RECALL_PU_CYC(23'h28), .STORE_CYC(23'h3c), .WAKE_CYC(23'h32),
    .SLEEP_CYC(23'h1e), .RECALL_CYC(23'h2d))
  nvs_sequencer_inst (.sys_clk(sys_clk), .rst_b(rst_b), .vcc_ok(vcc_ok), .cs_b(cs_b),
    .cmd_store(cmd[0]), .cmd_recall(cmd[1]), .cmd_save_en(cmd[2]), .cmd_save_dis(cmd[3]),
    .cmd_sleep(cmd[4]), .cmd_wake(cmd[5]), .sram_write(wr), .sram_access_en_r(acc),
    .io_blocked_r(iob), .busy_r(busy), .sleep_r(slp), .standby_r(sb), .nv_store_go_r(sgo),
    .nv_recall_go_r(rgo), .power_fail_save_en_r(pfs));
  task ck(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task go(input int k);
    nvs_host_model_inst.issue(k);
  endtask
  // s picks the awaited state: 0 idle, 1 asleep, 2 standby
  task wt(input int s, input int lim);
    n = 0;
    while (!(s == 0 ? busy === 1'b0 : s == 1 ? slp === 1'b1 : sb === 1'b1) && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task t_store;
    wr = 1;
    cyc(1);
    wr = 0;
    go(0);
    cyc(3);
    ck(acc, 1);
    ck(iob, 1);
    cyc(5);
    ck(acc, 0);
    ck(sgo, 1);
    wt(0, 70);
    ck(n > 50 && n < 70, 1);
    go(1);
    cyc(8);
    ck(rgo, 1);
    wt(0, 55);
    ck(n < 55, 1);
    $display("store and recall done");
  endtask
  task t_fail(input logic dirty);
    logic seen;
    seen = 0;
    wr = dirty;
    cyc(1);
    wr = 0;
    vcc_ok = 0;
    repeat (8) begin
      cyc(1);
      seen |= sgo;
    end
    ck(seen, dirty);
    ck(acc, 0);
    vcc_ok = 1;
    cyc(4);
    wt(0, 60);
    ck(n < 60 && acc, 1);
    $display("power loss done");
  endtask
  task t_modes;
    go(3);
    cyc(12);
    ck(pfs, 0);
    go(2);
    ck(pfs, 1);
    // standby at its full time: 100 us is 25000 cycles of 4 ns
    wt(2, 25000);
    ck(n < 25000, 1);
    go(4);
    wt(1, 50);
    ck(n < 50, 1);
    go(5);
    cyc(2);
    wt(0, 70);
    ck(n < 70 && !slp, 1);
    $display("modes done");
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(6);
    rst_b = 1;
    cyc(4);
    wt(0, 50);
    ck(n < 50 && acc, 1);
    t_store;
    t_fail(0);
    t_fail(1);
    t_modes;
    finish_test;
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    finish_test;
  end
endmodule // tb
